// ===== pkg/rtc_pkg.sv
// Register map, field layout, reset values and types of the real-time counter
package rtc_pkg;

    // Register indices; byte address is four times the index
    localparam logic [3:0] IDX_MAIN_CONTROL = 4'h0;
    localparam logic [3:0] IDX_SYNC_BUSY = 4'h1;
    localparam logic [3:0] IDX_IRQ_ENABLE = 4'h2;
    localparam logic [3:0] IDX_IRQ_FLAGS = 4'h3;
    localparam logic [3:0] IDX_BUFFER = 4'h4;
    localparam logic [3:0] IDX_DEBUG = 4'h5;
    localparam logic [3:0] IDX_CLK_SOURCE = 4'h7;
    localparam logic [3:0] IDX_COUNT_LO = 4'h8;
    localparam logic [3:0] IDX_COUNT_HI = 4'h9;
    localparam logic [3:0] IDX_TOP_LO = 4'ha;
    localparam logic [3:0] IDX_TOP_HI = 4'hb;
    localparam logic [3:0] IDX_MATCH_LO = 4'hc;
    localparam logic [3:0] IDX_MATCH_HI = 4'hd;

    // Busy flag positions, also the sync channel numbers
    localparam int BUSY_CONTROL = 0;
    localparam int BUSY_COUNT = 1;
    localparam int BUSY_TOP = 2;
    localparam int BUSY_MATCH = 3;
    localparam int SYNC_CHANNELS = 4;

    // Interrupt flag and enable positions
    localparam int IRQ_WRAP_BIT = 0;
    localparam int IRQ_MATCH_BIT = 1;

    // Writable masks of the byte registers
    localparam logic [7:0] MAIN_CONTROL_MASK = 8'hf9;
    localparam logic [1:0] IRQ_MASK = 2'h3;

    // Reset values
    localparam logic [7:0] MAIN_CONTROL_RST = 8'h00;
    localparam logic [1:0] IRQ_ENABLE_RST = 2'h0;
    localparam logic [1:0] IRQ_FLAGS_RST = 2'h0;
    localparam logic [7:0] BUFFER_RST = 8'h00;
    localparam logic DEBUG_RST = 1'b0;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [15:0] TOP_RST = 16'hffff;
    localparam logic [15:0] MATCH_RST = 16'h0000;

    // Timebase ticks from a write until it acts
    localparam logic [1:0] SYNC_TICKS = 2'd2;

    // Prescaler width, enough for division by 32768
    localparam int PRESCALE_W = 15;

    // Timebase source codes
    typedef enum logic [1:0] {
        SRC_OSC_32K = 2'b00,
        SRC_OSC_1K = 2'b01,
        SRC_RESERVED = 2'b10,
        SRC_EXT_PIN = 2'b11
    } timebase_source_t;

    // Bus answer state
    typedef enum logic {
        APB_IDLE = 1'b0,
        APB_ANSWER = 1'b1
    } apb_state_t;

    // Layout of main_control, bit 7 down to bit 0
    typedef struct packed {
        logic keep_running_asleep;
        logic [3:0] divider;
        logic [1:0] unused;
        logic counter_on;
    } main_control_t;

    // Per-channel synchronisation state
    typedef struct packed {
        logic pending;
        logic [1:0] ticks;
    } sync_t;

endpackage : rtc_pkg

// ===== src/rtc_counter_control_regs.sv
// Real-time counter control and status registers on APB
//
// Functional notes
// RULE_01 - Standby stops counter unless run-asleep bit set
// RULE_02 - Prescaler divides timebase by two to divider
// RULE_03 - Control change acts after two timebase ticks
// RULE_04 - Software waits for control busy clear
// RULE_05 - Bit 0 enables the counter
// RULE_06 - Busy flags show pending synchronisation per register
// RULE_07 - Match enable bit requests match interrupt
// RULE_08 - Wrap enable bit requests wrap interrupt
// RULE_09 - Counter wraps to zero after top
// RULE_10 - Match flag set on match, write-one clears
// RULE_11 - Wrap flag set on wrap, write-one clears
// RULE_12 - Byte buffer gives atomic 16-bit access
// RULE_13 - One shared buffer, directly readable and writable
// RULE_14 - Debug halt freezes counter unless run bit
// RULE_15 - Run bit keeps counter going while halted
// RULE_16 - Source field selects 32k, 1k or pin
// RULE_17 - Request held while flag and enable set
// RULE_18 - Busy set on write, cleared after sync
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
module rtc_counter_control_regs #(
    parameter int ADDR_W = 8  // APB address width
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic osc_32k_tick,  // One-cycle pulse per 32 kHz period
    input wire logic osc_1k_tick,  // One-cycle pulse per 1 kHz period
    input wire logic external_timebase_pin,  // Slow clock level from the pin
    input wire logic standby_sleep,  // High while the system is in standby
    input wire logic debug_halt,  // High while the processor is halted by debug
    output logic irq,
    output logic wrap_event_pulse,
    output logic match_value_pulse
);
    import rtc_pkg::*;

    // Bus-side state
    apb_state_t state, next_state;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic [7:0] read_hi, next_read_hi;  // High byte for the buffer
    main_control_t control_bus, next_control_bus;  // Last written control value
    logic [1:0] irq_enable, next_irq_enable;
    logic [1:0] irq_flags, next_irq_flags;
    logic [7:0] buffer, next_buffer;  // Shared byte buffer
    logic run_when_halted, next_run_when_halted;
    timebase_source_t timebase_source, next_timebase_source;
    logic [15:0] count_bus, next_count_bus;  // Value waiting to load the counter
    logic [15:0] top_bus, next_top_bus;
    logic [15:0] match_bus, next_match_bus;
    logic [SYNC_CHANNELS-1:0] sync_start;  // Write pulse per channel

    // Sync state
    sync_t sync_q [SYNC_CHANNELS];
    sync_t next_sync [SYNC_CHANNELS];
    logic [SYNC_CHANNELS-1:0] sync_done;  // Channel lands this cycle
    logic [SYNC_CHANNELS-1:0] busy;

    // Timebase-side state
    main_control_t control_act, next_control_act;  // Control value the counter obeys
    logic [15:0] top_act, next_top_act;
    logic [15:0] match_act, next_match_act;
    logic [15:0] count_value, next_count_value;
    logic [PRESCALE_W-1:0] prescale, next_prescale;
    logic pin_prev, next_pin_prev;
    logic next_wrap_pulse, next_match_pulse;

    // Combinational helpers
    logic access, done, wr, rd;
    logic [3:0] idx;
    logic tick_sel, live_tick, step;
    logic [1:0] events;

    // Aligned, in-range and mapped address
    function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
        logic [3:0] i;
        i = addr[5:2];
        if (addr[1:0] != 2'b00 || (addr >> 6) != '0) begin
            return 1'b0;
        end
        case (i)
            IDX_MAIN_CONTROL, IDX_SYNC_BUSY, IDX_IRQ_ENABLE, IDX_IRQ_FLAGS, IDX_BUFFER, IDX_DEBUG,
            IDX_CLK_SOURCE, IDX_COUNT_LO, IDX_COUNT_HI, IDX_TOP_LO, IDX_TOP_HI, IDX_MATCH_LO,
            IDX_MATCH_HI: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : is_mapped

    // All-ones mask over the low divider bits
    function automatic logic [PRESCALE_W-1:0] div_mask(input logic [3:0] div);
        logic [PRESCALE_W:0] full;
        full = (16'h0001 << div) - 16'h0001;
        return full[PRESCALE_W-1:0];
    endfunction : div_mask

    assign idx = paddr[5:2];
    assign access = psel & penable;
    assign done = access & (state == APB_ANSWER);
    assign wr = done & pwrite & ~pslverr & pstrb[0];
    assign rd = done & ~pwrite & ~pslverr;
    assign pready = (state == APB_ANSWER);  // One wait state so read data leaves a flop
    assign irq = |(irq_flags & irq_enable);  // Level held while a flag and its enable are both set [RULE_07] [RULE_08] [RULE_17]

    // Busy flags read straight from the channel state
    always_comb begin
        for (int i = 0; i < SYNC_CHANNELS; i++) begin
            busy[i] = sync_q[i].pending;
        end
    end

    // Bus next-state: decode, reads and writes
    always_comb begin
        next_state = state;
        next_prdata = prdata;
        next_pslverr = pslverr;
        next_read_hi = read_hi;
        next_control_bus = control_bus;
        next_irq_enable = irq_enable;
        next_irq_flags = irq_flags;
        next_buffer = buffer;
        next_run_when_halted = run_when_halted;
        next_timebase_source = timebase_source;
        next_count_bus = count_bus;
        next_top_bus = top_bus;
        next_match_bus = match_bus;
        sync_start = '0;
        case (state)
            APB_IDLE: begin
                // First access cycle: capture answer
                if (access) begin
                    next_state = APB_ANSWER;
                    next_pslverr = ~is_mapped(paddr);
                    next_prdata = 32'h0000_0000;
                    next_read_hi = 8'h00;
                    case (idx)
                        IDX_MAIN_CONTROL: next_prdata[7:0] = control_bus;
                        IDX_SYNC_BUSY: next_prdata[3:0] = busy;  // [RULE_06]
                        IDX_IRQ_ENABLE: next_prdata[1:0] = irq_enable;
                        IDX_IRQ_FLAGS: next_prdata[1:0] = irq_flags;
                        IDX_BUFFER: next_prdata[7:0] = buffer;  // [RULE_13]
                        IDX_DEBUG: next_prdata[0] = run_when_halted;
                        IDX_CLK_SOURCE: next_prdata[1:0] = timebase_source;
                        IDX_COUNT_LO: begin
                            // Both bytes sampled at once [RULE_12]
                            next_prdata[7:0] = count_value[7:0];
                            next_read_hi = count_value[15:8];
                        end
                        IDX_TOP_LO: begin
                            next_prdata[7:0] = top_bus[7:0];
                            next_read_hi = top_bus[15:8];
                        end
                        IDX_MATCH_LO: begin
                            next_prdata[7:0] = match_bus[7:0];
                            next_read_hi = match_bus[15:8];
                        end
                        // High bytes come from the buffer [RULE_12]
                        IDX_COUNT_HI, IDX_TOP_HI, IDX_MATCH_HI: next_prdata[7:0] = buffer;
                        default: next_prdata = 32'h0000_0000;
                    endcase
                end
            end
            APB_ANSWER: begin
                // Transfer completes here
                next_state = APB_IDLE;
            end
            default: next_state = APB_IDLE;
        endcase

        // Low-byte read parks the high byte in the buffer [RULE_12] [RULE_13]
        if (rd && (idx == IDX_COUNT_LO || idx == IDX_TOP_LO || idx == IDX_MATCH_LO)) begin
            next_buffer = read_hi;
        end

        // Writes act at the completing edge
        if (wr) begin
            case (idx)
                IDX_MAIN_CONTROL: begin
                    // Rewrite while busy restarts the sync
                    next_control_bus = main_control_t'(pwdata[7:0] & MAIN_CONTROL_MASK);
                    sync_start[BUSY_CONTROL] = 1'b1;  // [RULE_18]
                end
                IDX_IRQ_ENABLE: next_irq_enable = pwdata[1:0] & IRQ_MASK;
                IDX_BUFFER: next_buffer = pwdata[7:0];  // [RULE_13]
                IDX_DEBUG: next_run_when_halted = pwdata[0];
                IDX_CLK_SOURCE: next_timebase_source = timebase_source_t'(pwdata[1:0]);
                // Low byte waits in the buffer [RULE_12]
                IDX_COUNT_LO, IDX_TOP_LO, IDX_MATCH_LO: next_buffer = pwdata[7:0];
                IDX_COUNT_HI: begin
                    next_count_bus = {pwdata[7:0], buffer};  // [RULE_12]
                    sync_start[BUSY_COUNT] = 1'b1;  // [RULE_18]
                end
                IDX_TOP_HI: begin
                    next_top_bus = {pwdata[7:0], buffer};
                    sync_start[BUSY_TOP] = 1'b1;  // [RULE_18]
                end
                IDX_MATCH_HI: begin
                    next_match_bus = {pwdata[7:0], buffer};
                    sync_start[BUSY_MATCH] = 1'b1;  // [RULE_18]
                end
                default: ;  // Read-only or reserved: ignored
            endcase
        end

        // Write-one clears, but a new event in the same cycle wins [RULE_10] [RULE_11]
        if (wr && idx == IDX_IRQ_FLAGS) begin
            next_irq_flags = irq_flags & ~(pwdata[1:0] & IRQ_MASK);
        end
        next_irq_flags = next_irq_flags | events;
    end

    // Bus registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= APB_IDLE;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            read_hi <= 8'h00;
            control_bus <= main_control_t'(MAIN_CONTROL_RST);
            irq_enable <= IRQ_ENABLE_RST;
            irq_flags <= IRQ_FLAGS_RST;
            buffer <= BUFFER_RST;
            run_when_halted <= DEBUG_RST;
            timebase_source <= SRC_OSC_32K;
            count_bus <= COUNT_RST;
            top_bus <= TOP_RST;
            match_bus <= MATCH_RST;
        end else begin
            state <= next_state;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
            read_hi <= next_read_hi;
            control_bus <= next_control_bus;
            irq_enable <= next_irq_enable;
            irq_flags <= next_irq_flags;
            buffer <= next_buffer;
            run_when_halted <= next_run_when_halted;
            timebase_source <= next_timebase_source;
            count_bus <= next_count_bus;
            top_bus <= next_top_bus;
            match_bus <= next_match_bus;
        end
    end

    // Selected timebase tick; a pin rising edge counts [RULE_16]
    always_comb begin
        next_pin_prev = external_timebase_pin;
        case (timebase_source)
            SRC_OSC_32K: tick_sel = osc_32k_tick;
            SRC_OSC_1K: tick_sel = osc_1k_tick;
            SRC_EXT_PIN: tick_sel = external_timebase_pin & ~pin_prev;
            default: tick_sel = 1'b0;  // Reserved code gives no timebase
        endcase
    end

    // Sync next-state: a value crosses after two ticks
    always_comb begin
        for (int i = 0; i < SYNC_CHANNELS; i++) begin
            next_sync[i] = sync_q[i];
            sync_done[i] = sync_q[i].pending & tick_sel & (sync_q[i].ticks == SYNC_TICKS - 2'd1);  // [RULE_03]
            if (sync_start[i]) begin
                // A fresh write restarts so the newest value lands
                next_sync[i].pending = 1'b1;  // [RULE_18]
                next_sync[i].ticks = 2'd0;
            end else if (sync_done[i]) begin
                next_sync[i].pending = 1'b0;  // [RULE_06] [RULE_18]
                next_sync[i].ticks = 2'd0;
            end else if (sync_q[i].pending && tick_sel) begin
                next_sync[i].ticks = sync_q[i].ticks + 2'd1;
            end
        end
    end

    // Sync registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < SYNC_CHANNELS; i++) begin
                sync_q[i] <= '0;
            end
        end else begin
            for (int i = 0; i < SYNC_CHANNELS; i++) begin
                sync_q[i] <= next_sync[i];
            end
        end
    end

    // Counter next-state: gating, prescaler, wrap and match
    always_comb begin
        next_control_act = control_act;
        next_top_act = top_act;
        next_match_act = match_act;
        next_count_value = count_value;
        next_prescale = prescale;
        events = 2'b00;
        // Standby and debug halt both swallow ticks [RULE_01] [RULE_14] [RULE_15]
        live_tick = tick_sel & (~standby_sleep | control_act.keep_running_asleep)
            & (~debug_halt | run_when_halted);
        step = control_act.counter_on & live_tick
            & ((prescale & div_mask(control_act.divider)) == div_mask(control_act.divider));  // [RULE_02] [RULE_05]
        if (!control_act.counter_on) begin
            next_prescale = '0;  // [RULE_05]
        end else if (live_tick) begin
            next_prescale = prescale + 1'b1;  // [RULE_02]
        end
        if (step) begin
            // Match seen on the value held at the step
            events[IRQ_MATCH_BIT] = (count_value == match_act);  // [RULE_10]
            if (count_value == top_act) begin
                next_count_value = 16'h0000;  // [RULE_09]
                events[IRQ_WRAP_BIT] = 1'b1;  // [RULE_11]
            end else begin
                next_count_value = count_value + 16'h0001;
            end
        end
        // Synchronised values land; a count load beats a step
        if (sync_done[BUSY_CONTROL]) begin
            next_control_act = control_bus;  // [RULE_03]
        end
        if (sync_done[BUSY_COUNT]) begin
            next_count_value = count_bus;
        end
        if (sync_done[BUSY_TOP]) begin
            next_top_act = top_bus;
        end
        if (sync_done[BUSY_MATCH]) begin
            next_match_act = match_bus;
        end
        next_wrap_pulse = events[IRQ_WRAP_BIT];
        next_match_pulse = events[IRQ_MATCH_BIT];
    end

    // Counter registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_act <= main_control_t'(MAIN_CONTROL_RST);
            top_act <= TOP_RST;
            match_act <= MATCH_RST;
            count_value <= COUNT_RST;
            prescale <= '0;
            pin_prev <= 1'b0;
            wrap_event_pulse <= 1'b0;
            match_value_pulse <= 1'b0;
        end else begin
            control_act <= next_control_act;
            top_act <= next_top_act;
            match_act <= next_match_act;
            count_value <= next_count_value;
            prescale <= next_prescale;
            pin_prev <= next_pin_prev;
            wrap_event_pulse <= next_wrap_pulse;
            match_value_pulse <= next_match_pulse;
        end
    end

endmodule : rtc_counter_control_regs

// ===== test/rtc_counter_control_regs_monitor.sv
// Checker of bus timing, busy, irq and debug gating
`timescale 1ns/1ps
module rtc_counter_control_regs_monitor
    import rtc_pkg::*;
#(
    parameter int ADDR_W = 8  // Bus address width
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic osc_32k_tick,
    input wire logic osc_1k_tick,
    input wire logic external_timebase_pin,
    input wire logic debug_halt,
    input wire logic irq,
    input wire logic wrap_event_pulse,
    input wire logic match_value_pulse
);
    logic done;  // Transfer ends
    logic wr_done;  // Write acts
    logic [3:0] idx;  // Register index
    logic mapped;  // Hits a register
    logic dbg_run;  // Debug run shadow
    logic next_dbg_run;
    logic rd_status;  // Status read ends
    assign done = psel && penable && pready;
    assign wr_done = done && pwrite && pstrb[0] && mapped;
    assign idx = paddr[5:2];
    assign mapped = paddr[1:0] == 2'h0 && paddr[ADDR_W-1:6] == '0 && idx != 4'h6 && idx < 4'he;
    assign rd_status = done && !pwrite && mapped && idx == IDX_SYNC_BUSY;
    // Shadow follows completed debug writes
    always_comb begin
        next_dbg_run = dbg_run;
        if (wr_done && idx == IDX_DEBUG) begin
            next_dbg_run = pwdata[0];
        end
    end
    // Shadow register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dbg_run <= 1'b0;
        end else begin
            dbg_run <= next_dbg_run;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_READY_WAIT: assert property (psel && $rose(penable) |-> !pready ##1 pready)
        else $error("ready timing");
    AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
        else $error("stray ready");
    AST_UNMAPPED_ERR: assert property (done && !mapped |-> pslverr)
        else $error("no error on unmapped");
    AST_MAPPED_OK: assert property (done && mapped |-> !pslverr)
        else $error("false error");
    AST_STATUS_BITS: assert property (rd_status |-> prdata[31:4] == 28'h0)
        else $error("status high bits");
    AST_FLAG_BITS: assert property (done && !pwrite && mapped && idx == IDX_IRQ_FLAGS |-> prdata[31:2] == 30'h0)
        else $error("flag high bits");
    AST_BUSY_HELD: assert property (wr_done && idx == IDX_MAIN_CONTROL ##1
        (!osc_32k_tick && !osc_1k_tick && $stable(external_timebase_pin))[*4] ##0 rd_status |-> prdata[0])
        else $error("busy lost");
    AST_IRQ_FALL: assert property ($fell(irq) |-> $past(wr_done && (idx == IDX_IRQ_FLAGS || idx == IDX_IRQ_ENABLE)))
        else $error("irq fell alone");
    AST_IRQ_RISE: assert property ($rose(irq) |-> wrap_event_pulse || match_value_pulse ||
        $past(wr_done && idx == IDX_IRQ_ENABLE))
        else $error("irq rose alone");
    AST_HALT_FREEZE: assert property ($past(debug_halt) && !$past(dbg_run) |-> !wrap_event_pulse && !match_value_pulse)
        else $error("step while halted");
    cover property (wrap_event_pulse);
    cover property (match_value_pulse);
    cover property ($rose(irq));
    cover property (done && pslverr);
endmodule : rtc_counter_control_regs_monitor
bind rtc_counter_control_regs rtc_counter_control_regs_monitor #(.ADDR_W(ADDR_W)) u_monitor (.*);

// ===== test/rtc_counter_control_regs_tb.sv
// Self-checking bench of the real-time counter register block
`timescale 1ns/1ps
module rtc_counter_control_regs_tb;
    import rtc_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'h0;
    logic pready, pslverr, irq, wrap_event_pulse, match_value_pulse, err_seen;
    logic osc_32k_tick = 1'b0, osc_1k_tick = 1'b0, external_timebase_pin = 1'b0;
    logic standby_sleep = 1'b0, debug_halt = 1'b0, tick_en = 1'b1;  // Ticks gated for busy checks
    int error_cnt = 0, checked = 0, tb_cyc = 0, g;
    always #25 pclk = ~pclk;
    rtc_counter_control_regs u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .osc_32k_tick, .osc_1k_tick, .external_timebase_pin, .standby_sleep,
        .debug_halt, .irq, .wrap_event_pulse, .match_value_pulse);
    // Timebase sources: 32k tick every 8 cycles, 1k tick and pin edge every 32
    always @(posedge pclk) begin
        tb_cyc <= tb_cyc + 1;
        osc_32k_tick <= tick_en && (tb_cyc % 8 == 7);
        osc_1k_tick <= tick_en && (tb_cyc % 32 == 31);
        if (tick_en) begin
            external_timebase_pin <= tb_cyc[4];
        end
        if (tb_cyc == 20000) begin
            error_cnt++;
            close_out();
        end
    end
    task close_out;
        $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // One transfer, held until pready is seen high
    task xfer(input logic w, input logic [3:0] idx, input logic [7:0] wd);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, wd};
        pstrb <= 4'hf;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer
    task wr(input logic [3:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, d);
    endtask : wr
    task rd_chk(input string what, input logic [3:0] idx, input logic [31:0] exp);
        xfer(1'b0, idx, 8'h00);
        chk(what, exp, rd);
    endtask : rd_chk
    task wr16(input logic [3:0] idx, input logic [15:0] v);
        wr(idx, v[7:0]);  // Low byte parks in the buffer
        wr(idx + 4'h1, v[15:8]);
    endtask : wr16
    task wait_idle;
        rd = 32'h1;
        while (rd[3:0] !== 4'h0) xfer(1'b0, IDX_SYNC_BUSY, 8'h00);
    endtask : wait_idle
    task set_ctrl(input logic [7:0] v);
        wr(IDX_MAIN_CONTROL, v);
        wait_idle();
    endtask : set_ctrl
    // Cycles between two wrap pulses
    task gap;
        while (wrap_event_pulse !== 1'b1) @(posedge pclk);
        @(posedge pclk);
        g = 1;
        while (wrap_event_pulse !== 1'b1) begin
            @(posedge pclk);
            g++;
        end
    endtask : gap
    // No step may show after two settling edges
    task quiet(input int n, input string what);
        int c;
        c = 0;
        repeat (2) @(posedge pclk);
        repeat (n) begin
            @(posedge pclk);
            if (wrap_event_pulse === 1'b1 || match_value_pulse === 1'b1) c++;
        end
        chk(what, 32'h0, c);
    endtask : quiet
    task automatic t_map;
        logic [3:0] ix [9] = '{IDX_MAIN_CONTROL, IDX_SYNC_BUSY, IDX_IRQ_ENABLE, IDX_IRQ_FLAGS, IDX_BUFFER,
            IDX_DEBUG, IDX_CLK_SOURCE, IDX_TOP_LO, IDX_TOP_HI};
        for (int i = 0; i < 9; i++) rd_chk("reset value", ix[i], (i > 6) ? 32'hff : 32'h0);
        wr(IDX_SYNC_BUSY, 8'hff);
        rd_chk("status read only", IDX_SYNC_BUSY, 32'h0);
        xfer(1'b0, 4'h6, 8'h00);
        chk("unmapped error", 32'h1, err_seen);
    endtask : t_map
    task t_buffer;
        wr(IDX_BUFFER, 8'h5a);
        rd_chk("buffer", IDX_BUFFER, 32'h5a);
        wr16(IDX_MATCH_LO, 16'h1234);
        rd_chk("buffer after pair", IDX_BUFFER, 32'h34);
        rd_chk("match low", IDX_MATCH_LO, 32'h34);
        rd_chk("buffer holds high", IDX_BUFFER, 32'h12);
        rd_chk("match high", IDX_MATCH_HI, 32'h12);
        wait_idle();
    endtask : t_buffer
    task t_busy;
        tick_en <= 1'b0;
        repeat (2) @(posedge pclk);
        wr16(IDX_TOP_LO, 16'h0003);
        wr16(IDX_COUNT_LO, 16'h0001);
        wr(IDX_MAIN_CONTROL, 8'h01);
        rd_chk("busy set", IDX_SYNC_BUSY, 32'h7);
        tick_en <= 1'b1;
        while (osc_32k_tick !== 1'b1) @(posedge pclk);
        rd_chk("busy over one tick", IDX_SYNC_BUSY, 32'h7);
        wait_idle();
        wr16(IDX_MATCH_LO, 16'h0002);
        rd_chk("match busy", IDX_SYNC_BUSY, 32'h8);
        wait_idle();
    endtask : t_busy
    task t_events;
        wr(IDX_IRQ_ENABLE, 8'h03);
        gap();
        chk("wrap gap", 32'd32, g);
        rd_chk("flags", IDX_IRQ_FLAGS, 32'h3);
        chk("irq on", 32'h1, irq);
        wr(IDX_IRQ_ENABLE, 8'h00);
        chk("irq masked", 32'h0, irq);
        wr(IDX_IRQ_ENABLE, 8'h01);
        set_ctrl(8'h00);
        chk("irq wrap", 32'h1, irq);
        wr(IDX_IRQ_FLAGS, 8'h01);
        rd_chk("wrap cleared", IDX_IRQ_FLAGS, 32'h2);
        chk("irq off", 32'h0, irq);
        wr(IDX_IRQ_ENABLE, 8'h02);
        chk("irq match", 32'h1, irq);
        wr(IDX_IRQ_FLAGS, 8'h02);
        rd_chk("match cleared", IDX_IRQ_FLAGS, 32'h0);
    endtask : t_events
    task t_prescale;
        for (int d = 1; d < 4; d += 2) begin
            set_ctrl({1'b0, 4'(d), 3'b001});
            gap();
            chk("prescaled gap", 32'd32 << d, g);
        end
    endtask : t_prescale
    task t_gate;
        set_ctrl(8'h01);
        debug_halt <= 1'b1;
        quiet(100, "halted");
        wr(IDX_DEBUG, 8'h01);
        gap();
        chk("run when halted", 32'd32, g);
        wr(IDX_DEBUG, 8'h00);
        debug_halt <= 1'b0;
        standby_sleep <= 1'b1;
        quiet(100, "standby");
        set_ctrl(8'h81);
        gap();
        chk("run asleep", 32'd32, g);
        standby_sleep <= 1'b0;
        set_ctrl(8'h80);
        quiet(100, "disabled");
    endtask : t_gate
    task t_source;
        set_ctrl(8'h01);
        wr(IDX_CLK_SOURCE, 8'h01);
        gap();
        chk("1k gap", 32'd128, g);
        wr(IDX_CLK_SOURCE, 8'h03);
        rd_chk("source", IDX_CLK_SOURCE, 32'h3);
        gap();
        chk("pin gap", 32'd128, g);
        wr(IDX_CLK_SOURCE, 8'h02);
        quiet(300, "reserved source");
        wr(IDX_CLK_SOURCE, 8'h00);
    endtask : t_source
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_map();
        t_buffer();
        t_busy();
        t_events();
        t_prescale();
        t_gate();
        t_source();
        close_out();
    end
endmodule : rtc_counter_control_regs_tb
